// ==== rtl/sep_pkg.sv ====
// constants and types shared by the eeprom command and protect logic
package sep_pkg;

  // one-byte instruction codes
  localparam logic [7:0] LATCH_SET_CMD = 8'h06;
  localparam logic [7:0] LATCH_CLEAR_CMD = 8'h04;
  localparam logic [7:0] STATUS_READ_CMD = 8'h05;
  localparam logic [7:0] STATUS_WRITE_CMD = 8'h01;
  localparam logic [7:0] ARRAY_READ_CMD = 8'h03;
  localparam logic [7:0] ARRAY_WRITE_CMD = 8'h02;
  localparam logic [7:0] ID_READ_CMD = 8'h83;
  localparam logic [7:0] ID_WRITE_CMD = 8'h82;

  // status byte field positions
  localparam int STATUS_LOCK_POS = 7;
  localparam int PROTECT_HI_POS = 3;
  localparam int PROTECT_LO_POS = 2;
  localparam int WRITE_LATCH_POS = 1;
  localparam int BUSY_POS = 0;

  // nonvolatile bits as seen after reset (delivery state)
  localparam logic STATUS_LOCK_RESET = 1'b0;
  localparam logic [1:0] PROTECT_SEL_RESET = 2'b00;

  // array address width and protected area starts
  localparam int ADDR_W = 13;
  localparam logic [12:0] QUARTER_BASE = 13'h1800;
  localparam logic [12:0] HALF_BASE = 13'h1000;
  localparam int ID_A10_POS = 2;

  // self-timed write duration
  localparam int SELF_WRITE_TIME_US = 5000;
  localparam int CLK_FREQ_KHZ = 50000;
  localparam int SELF_WRITE_CYCLES = SELF_WRITE_TIME_US * CLK_FREQ_KHZ / 1000;
  localparam int WRITE_CNT_W = 18;

  // pin synchroniser init: deselected, clock low, data low, protect high
  localparam logic [3:0] PIN_INIT = 4'h9;

  // synchronised pin group
  typedef struct packed {
    logic sel_n;
    logic sclk;
    logic din;
    logic protect_n;
  } sep_pins_t;

endpackage

// ==== rtl/sep_pin_sync.sv ====
// three-flop synchronisers with agreement filter for the serial pins
`timescale 1ns/1ps
`default_nettype none
module sep_pin_sync #(
  parameter int W = 4,
  parameter logic [3:0] INIT = 4'h0
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] stable
);

  // per bit: three stages, output moves once stages two and three agree
  for (genvar i = 0; i < W; i++)
  begin : g_bit
    logic s1_q;
    logic s2_q;
    logic s3_q;
    always_ff @(posedge clk)
    begin
      if (reset)
      begin
        s1_q <= INIT[i];
        s2_q <= INIT[i];
        s3_q <= INIT[i];
        stable[i] <= INIT[i];
      end
      else
      begin
        s1_q <= async_in[i];
        s2_q <= s1_q;
        s3_q <= s2_q;
        if (s2_q == s3_q)
          stable[i] <= s3_q;
      end
    end
  end

endmodule
`default_nettype wire

// ==== rtl/sep_cmd_core.sv ====
// instruction decoder, status register and write protection of the eeprom
// What this block does
// - opcodes 06 set, 04 clear, 05 status read
// - array read 03, status write 01
// - array write opcode is 02
// - id variant also accepts 83 and 82
// - unknown opcode ignores rest until deselect
// - latch set takes effect at deselect
// - latch clear takes effect at deselect
// - latch cleared at reset, clear, write end
// - status read anytime, byte repeats while selected
// - busy flag high during self-timed cycle
// - latch low rejects both write instructions
// - protect bits via status write, not hard-protected
// - lock and protect pin low: hard protection
// - misplaced release aborts; boundary starts cycle
// - write latch cleared at cycle end, not at start
// - new protect values apply after cycle
// - bits six to four read zero, unchanged
// - soft mode: writable status, protected areas refuse
// - protect codes: none, 1800h, 1000h, whole
// - writes need clock count multiple of eight
// - sample on rising, drive on falling edge
// - id read: A10 zero, low five select
`timescale 1ns/1ps
`default_nettype none
module sep_cmd_core
  import sep_pkg::*;
#(
  parameter int unsigned WRITE_CYCLES = SELF_WRITE_CYCLES,
  parameter bit HAS_ID_PAGE = 1'b1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic spi_sel_n,
  input wire logic spi_sclk,
  input wire logic spi_din,
  input wire logic protect_pin_n,
  output logic spi_dout,
  output logic spi_dout_en,
  output logic mem_write_start,
  output logic [ADDR_W-1:0] mem_write_addr,
  output logic id_page_read,
  output logic [4:0] id_page_index
);

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_OPCODE,
    ST_WAIT_SET,
    ST_WAIT_CLEAR,
    ST_STATUS_OUT,
    ST_STATUS_WRITE_CMD_DATA,
    ST_STATUS_WRITE_CMD_END,
    ST_WR_ADDR,
    ST_WR_DATA,
    ST_READ,
    ST_ID,
    ST_IGNORE
  } sep_state_t;

  sep_pins_t pins;
  sep_pins_t prev_q;
  sep_state_t state_q;
  logic [2:0] bit_cnt_q;
  logic [1:0] byte_cnt_q;
  logic [7:0] shift_q;
  logic [7:0] out_sh_q;
  logic [2:0] out_cnt_q;
  logic data_seen_q;
  logic id_is_read_q;
  logic [ADDR_W-1:0] addr_q;
  logic [7:0] status_write_cmd_data_q;
  logic write_latch_flag_q;
  logic cycle_busy_flag_q;
  logic is_status_cycle_q;
  logic [WRITE_CNT_W-1:0] wcnt_q;
  logic status_lock_bit_q;
  logic protect_sel_hi_q;
  logic protect_sel_lo_q;
  logic sclk_rise;
  logic sclk_fall;
  logic sel_fall;
  logic sel_rise;
  logic selected;
  logic byte_done;
  logic [7:0] new_byte;
  logic [7:0] status_byte;
  logic hard_protect_mode;
  logic start_status;
  logic start_array;
  logic cycle_end;
  logic addr_protected;

  // synchronise all pins coming from the host
  sep_pin_sync #(
    .W(4),
    .INIT(PIN_INIT)
  ) u_sync (
    .clk(clk),
    .reset(reset),
    .async_in({spi_sel_n, spi_sclk, spi_din, protect_pin_n}),
    .stable(pins)
  );

  // edge detection on the filtered pins
  always_ff @(posedge clk)
  begin
    if (reset)
      prev_q <= sep_pins_t'(PIN_INIT);
    else
      prev_q <= pins;
  end

  assign selected = ~pins.sel_n & ~prev_q.sel_n;
  assign sel_fall = ~pins.sel_n & prev_q.sel_n;
  assign sel_rise = pins.sel_n & ~prev_q.sel_n;
  assign sclk_rise = selected & pins.sclk & ~prev_q.sclk;
  assign sclk_fall = selected & ~pins.sclk & prev_q.sclk;
  assign new_byte = {shift_q[6:0], pins.din};
  assign byte_done = sclk_rise & (bit_cnt_q == 3'd7);

  // hard protection from lock bit and pin
  assign hard_protect_mode = status_lock_bit_q & ~pins.protect_n;

  always_comb
  begin
    status_byte = 8'h00;
    status_byte[STATUS_LOCK_POS] = status_lock_bit_q;
    status_byte[PROTECT_HI_POS] = protect_sel_hi_q;
    status_byte[PROTECT_LO_POS] = protect_sel_lo_q;
    status_byte[WRITE_LATCH_POS] = write_latch_flag_q;
    status_byte[BUSY_POS] = cycle_busy_flag_q;
  end

  always_comb
  begin
    case ({protect_sel_hi_q, protect_sel_lo_q})
      2'b01: addr_protected = ({addr_q[12:8], new_byte} >= QUARTER_BASE);
      2'b10: addr_protected = ({addr_q[12:8], new_byte} >= HALF_BASE);
      2'b11: addr_protected = 1'b1;
      default: addr_protected = 1'b0;
    endcase
  end

  // release at byte boundary starts the cycle
  assign start_status = sel_rise & (state_q == ST_STATUS_WRITE_CMD_END)
    & (bit_cnt_q == 3'd0);
  assign start_array = sel_rise & (state_q == ST_WR_DATA) & data_seen_q
    & (bit_cnt_q == 3'd0);
  assign cycle_end = cycle_busy_flag_q & (wcnt_q == '0);

  // bit counter and input shift register
  always_ff @(posedge clk)
  begin
    if (reset || sel_fall)
    begin
      bit_cnt_q <= 3'd0;
      shift_q <= 8'h00;
    end
    else if (sclk_rise)
    begin
      bit_cnt_q <= bit_cnt_q + 3'd1;
      shift_q <= new_byte;
    end
  end

  // instruction state machine
  always_ff @(posedge clk)
  begin
    if (reset)
      state_q <= ST_IDLE;
    else if (sel_rise || pins.sel_n)
      state_q <= ST_IDLE;
    else if (sel_fall)
      state_q <= ST_OPCODE;
    else if (sclk_rise)
    begin
      case (state_q)
        ST_OPCODE:
        begin
          if (byte_done)
          begin
            case (new_byte)
              LATCH_SET_CMD: state_q <= ST_WAIT_SET;
              LATCH_CLEAR_CMD: state_q <= ST_WAIT_CLEAR;
              STATUS_READ_CMD: state_q <= ST_STATUS_OUT;
              STATUS_WRITE_CMD:
                state_q <= (write_latch_flag_q && !cycle_busy_flag_q
                  && !hard_protect_mode) ? ST_STATUS_WRITE_CMD_DATA : ST_IGNORE;
              ARRAY_READ_CMD:
                state_q <= cycle_busy_flag_q ? ST_IGNORE : ST_READ;
              ARRAY_WRITE_CMD:
                state_q <= (write_latch_flag_q && !cycle_busy_flag_q) ?
                  ST_WR_ADDR : ST_IGNORE;
              ID_READ_CMD, ID_WRITE_CMD:
                state_q <= HAS_ID_PAGE ? ST_ID : ST_IGNORE;
              default: state_q <= ST_IGNORE;
            endcase
          end
        end
        ST_STATUS_WRITE_CMD_DATA:
        begin
          if (byte_done)
            state_q <= ST_STATUS_WRITE_CMD_END;
        end
        // latch set, latch clear and status write end wait idle for deselect
        // any further clock voids the command
        ST_WAIT_SET, ST_WAIT_CLEAR, ST_STATUS_WRITE_CMD_END:
          state_q <= ST_IGNORE;
        ST_WR_ADDR:
        begin
          // nonzero protect blocks the selected area
          if (byte_done && byte_cnt_q == 2'd1)
            state_q <= addr_protected ? ST_IGNORE : ST_WR_DATA;
        end
        ST_STATUS_OUT, ST_WR_DATA, ST_READ, ST_ID, ST_IGNORE:
          state_q <= state_q;
        default: state_q <= ST_IGNORE;
      endcase
    end
  end

  // address and data bookkeeping after the opcode
  always_ff @(posedge clk)
  begin
    if (reset || sel_fall)
    begin
      byte_cnt_q <= 2'd0;
      data_seen_q <= 1'b0;
      id_is_read_q <= 1'b0;
    end
    else if (byte_done)
    begin
      if (state_q == ST_OPCODE)
        id_is_read_q <= (new_byte == ID_READ_CMD);
      if (byte_cnt_q != 2'd3 && state_q != ST_OPCODE)
        byte_cnt_q <= byte_cnt_q + 2'd1;
      if ((state_q == ST_WR_ADDR || state_q == ST_ID) && byte_cnt_q == 2'd0)
        addr_q[12:8] <= new_byte[4:0];
      if (state_q == ST_WR_ADDR && byte_cnt_q == 2'd1)
        addr_q[7:0] <= new_byte;
      if (state_q == ST_WR_DATA)
        data_seen_q <= 1'b1;
      if (state_q == ST_STATUS_WRITE_CMD_DATA)
        status_write_cmd_data_q <= new_byte;
    end
  end

  // id read: check A10, take low five bits
  always_ff @(posedge clk)
  begin
    if (reset || !selected)
    begin
      id_page_read <= 1'b0;
      id_page_index <= 5'h00;
    end
    else if (byte_done && state_q == ST_ID && id_is_read_q)
    begin
      // a10 came with the high address byte and must be zero
      if (byte_cnt_q == 2'd1)
      begin
        id_page_index <= new_byte[4:0];
        id_page_read <= ~addr_q[ID_A10_POS + 8];
      end
    end
  end

  // status output shifter, reloaded every byte
  // status byte repeats while selected
  // output changes on the falling edge
  always_ff @(posedge clk)
  begin
    if (reset || !selected)
    begin
      spi_dout <= 1'b0;
      spi_dout_en <= 1'b0;
      out_sh_q <= 8'h00;
      out_cnt_q <= 3'd0;
    end
    else if (byte_done && state_q == ST_OPCODE
      && new_byte == STATUS_READ_CMD)
    begin
      out_sh_q <= status_byte;
      out_cnt_q <= 3'd0;
      spi_dout_en <= 1'b1;
    end
    else if (sclk_fall && state_q == ST_STATUS_OUT)
    begin
      spi_dout <= out_sh_q[7];
      out_cnt_q <= out_cnt_q + 3'd1;
      if (out_cnt_q == 3'd7)
        out_sh_q <= status_byte;
      else
        out_sh_q <= {out_sh_q[6:0], 1'b0};
    end
  end

  // write enable latch
  // cleared at reset, clear command, cycle end
  always_ff @(posedge clk)
  begin
    if (reset)
      write_latch_flag_q <= 1'b0;
    else
    begin
      // cleared at the end of the cycle, not at its start
      if (cycle_end)
        write_latch_flag_q <= 1'b0;
      if (sel_rise && state_q == ST_WAIT_CLEAR)
        write_latch_flag_q <= 1'b0;
      // set applied at deselect, wins over clear
      // the only way to set the latch
      if (sel_rise && state_q == ST_WAIT_SET)
        write_latch_flag_q <= 1'b1;
    end
  end

  // self-timed write cycle timer
  // duration is a parameter count
  // busy held for the whole cycle
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      cycle_busy_flag_q <= 1'b0;
      is_status_cycle_q <= 1'b0;
      wcnt_q <= '0;
      mem_write_start <= 1'b0;
      mem_write_addr <= '0;
    end
    else
    begin
      mem_write_start <= 1'b0;
      if (start_status || start_array)
      begin
        cycle_busy_flag_q <= 1'b1;
        is_status_cycle_q <= start_status;
        wcnt_q <= WRITE_CNT_W'(WRITE_CYCLES - 1);
        mem_write_start <= start_array;
        if (start_array)
          mem_write_addr <= addr_q;
      end
      else if (cycle_end)
        cycle_busy_flag_q <= 1'b0;
      else if (cycle_busy_flag_q)
        wcnt_q <= wcnt_q - WRITE_CNT_W'(1);
    end
  end

  // nonvolatile lock and protect bits
  // new values only after the cycle ends
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      status_lock_bit_q <= STATUS_LOCK_RESET;
      protect_sel_hi_q <= PROTECT_SEL_RESET[1];
      protect_sel_lo_q <= PROTECT_SEL_RESET[0];
    end
    else if (cycle_end && is_status_cycle_q)
    begin
      status_lock_bit_q <= status_write_cmd_data_q[STATUS_LOCK_POS];
      protect_sel_hi_q <= status_write_cmd_data_q[PROTECT_HI_POS];
      protect_sel_lo_q <= status_write_cmd_data_q[PROTECT_LO_POS];
    end
  end

  // host polls busy; host times its release

endmodule
`default_nettype wire

// ==== verification/sep_cmd_core_asserts.sv ====
// port assertions for the eeprom command core
`timescale 1ns/1ps
`default_nettype none
module sep_cmd_core_asserts #(
  parameter int unsigned WRITE_CYCLES = 20
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic spi_sel_n,
  input wire logic spi_dout_en,
  input wire logic mem_write_start,
  input wire logic id_page_read,
  input wire logic [4:0] id_page_index
);
  int unsigned gap_q;

  // cycles since the last write start, saturating
  always_ff @(posedge clk)
  begin
    if (reset)
      gap_q <= WRITE_CYCLES;
    else if (mem_write_start)
      gap_q <= 1;
    else if (gap_q < WRITE_CYCLES)
      gap_q <= gap_q + 1;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence desel_s; spi_sel_n [*8]; endsequence
  sequence held_s; (!spi_sel_n) [*6]; endsequence
  sequence pulse_s; mem_write_start ##1 (!mem_write_start) [*8]; endsequence

  a_desel_quiet: assert property (desel_s |-> !spi_dout_en)
    else $error("output enabled while deselected");
  a_enable_held: assert property (held_s ##0 spi_dout_en |=> spi_dout_en)
    else $error("output dropped while selected");
  a_enable_rise: assert property ($rose(spi_dout_en) |->
    !spi_sel_n && !$past(spi_sel_n, 6)) else $error("output without frame");
  a_id_cleared: assert property (desel_s |->
    !id_page_read && id_page_index == 5'h00) else $error("id state kept");
  a_id_in_frame: assert property ($rose(id_page_read) |->
    !$past(spi_sel_n, 6)) else $error("id read outside frame");
  a_start_pulse: assert property ($rose(mem_write_start) |-> pulse_s)
    else $error("write start not a single pulse");
  a_start_desel: assert property (mem_write_start |->
    spi_sel_n && !spi_dout_en) else $error("write start while selected");
  a_start_gap: assert property (mem_write_start |-> gap_q >= WRITE_CYCLES)
    else $error("write start during busy cycle");
endmodule

bind sep_cmd_core sep_cmd_core_asserts #(.WRITE_CYCLES(WRITE_CYCLES)) i_asserts (
  .clk(clk), .reset(reset), .spi_sel_n(spi_sel_n), .spi_dout_en(spi_dout_en),
  .mem_write_start(mem_write_start), .id_page_read(id_page_read),
  .id_page_index(id_page_index));
`default_nettype wire

// ==== verification/sep_spi_host.sv ====
// spi bus host model driving the eeprom pins
`timescale 1ns/1ps
`default_nettype none
module sep_spi_host (
  input wire logic clk,
  input wire logic cpol,
  input wire logic dout,
  output logic sel_n,
  output logic sclk,
  output logic din,
  output logic [7:0] rx_byte,
  output logic rx_valid
);
  // idle pins: deselected
  initial
  begin
    sel_n = 1'b1;
    sclk = 1'b0;
    din = 1'b0;
    rx_byte = 8'h00;
    rx_valid = 1'b0;
  end

  // one framed transfer of n bits from a left-aligned buffer
  task automatic frame(input logic [39:0] d, input int n, input bit rd);
    logic [7:0] sh;
    sh = 8'h00;
    @(posedge clk);
    sclk <= cpol;
    repeat (4) @(posedge clk);
    sel_n <= 1'b0;
    repeat (4) @(posedge clk);
    for (int i = 0; i < n; i++)
    begin
      sclk <= 1'b0;
      din <= d[39 - i];
      repeat (4) @(posedge clk);
      sclk <= 1'b1;
      rx_valid <= 1'b0;
      repeat (4) @(posedge clk);
      sh = {sh[6:0], dout};
      if (rd && i > 7 && i % 8 == 7)
      begin
        rx_byte <= sh;
        rx_valid <= 1'b1;
      end
    end
    sel_n <= 1'b1;
    sclk <= cpol;
    din <= ~din;
    repeat (4) @(posedge clk);
    rx_valid <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ==== verification/sep_cmd_core_tb.sv ====
// self-checking bench for the eeprom command core
`timescale 1ns/1ps
`default_nettype none
module sep_cmd_core_tb;
  import sep_pkg::*;
  localparam int unsigned WC = 400;
  logic clk, reset, protect_pin_n, cpol, sel_n, sclk, din, dout;
  logic wstart, idrd, rxv;
  logic doe, dout_line;
  logic [4:0] idx_q[$];
  logic [7:0] rxb;
  logic [4:0] idx;
  logic [ADDR_W-1:0] waddr, a;
  logic [7:0] exp_q[$];
  logic [ADDR_W-1:0] addr_q[$];
  int miscompares, checks;

  sep_cmd_core #(.WRITE_CYCLES(WC)) i_dut (.clk(clk), .reset(reset),
    .spi_sel_n(sel_n), .spi_sclk(sclk), .spi_din(din),
    .protect_pin_n(protect_pin_n), .spi_dout(dout), .spi_dout_en(doe),
    .mem_write_start(wstart), .mem_write_addr(waddr),
    .id_page_read(idrd), .id_page_index(idx));
  sep_spi_host i_host (.clk(clk), .cpol(cpol), .dout(dout_line),
    .sel_n(sel_n), .sclk(sclk), .din(din), .rx_byte(rxb), .rx_valid(rxv));

  // undriven data line shows the inverse of the last bit
  assign dout_line = doe ? dout : ~dout;

  // system clock
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic fail(input string m);
    miscompares++;
    $display("mismatch at %0t: %s", $time, m);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // status read expecting n copies of one byte
  task automatic rd(input logic [7:0] e, input int n = 1);
    for (int k = 0; k < n; k++)
      exp_q.push_back(e);
    i_host.frame({STATUS_READ_CMD, 32'($urandom)}, 8 + 8 * n, 1'b1);
  endtask

  task automatic latch_set_cmd;
    i_host.frame({LATCH_SET_CMD, 32'h0}, 8, 1'b0);
  endtask

  task automatic status_write_cmd(input logic [7:0] d, input int n = 16);
    i_host.frame({STATUS_WRITE_CMD, d, 24'h0}, n, 1'b0);
  endtask

  // status bytes against notes
  always @(posedge rxv)
  begin
    #1;
    checks++;
    if (exp_q.size() == 0 || rxb !== exp_q[0])
      fail("status byte");
    if (exp_q.size() != 0)
      void'(exp_q.pop_front());
  end

  // write start address against notes
  always @(posedge wstart)
  begin
    #1;
    checks++;
    if (addr_q.size() == 0 || waddr !== addr_q[0])
      fail("write address");
    if (addr_q.size() != 0)
      void'(addr_q.pop_front());
  end

  // id page index
  always @(posedge idrd)
  begin
    #1;
    checks++;
    if (idx_q.size() == 0 || idx !== idx_q[0])
      fail("id index");
    if (idx_q.size() != 0)
      void'(idx_q.pop_front());
  end

  // watchdog
  initial
  begin
    repeat (30000) @(posedge clk);
    fail("timeout");
    tally_and_finish();
  end

  // main sequence
  initial
  begin
    void'($urandom(32'hf48b));
    reset = 1'b1;
    protect_pin_n = 1'b1;
    cpol = 1'b0;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    repeat (8) @(posedge clk);
    rd(8'h00);
    i_host.frame({8'hff, LATCH_SET_CMD, 24'h0}, 16, 1'b0);
    rd(8'h00);
    cpol <= 1'b1;
    i_host.frame({LATCH_SET_CMD, 32'h0}, 9, 1'b0);
    rd(8'h00);
    latch_set_cmd();
    rd(8'h02, 3);
    i_host.frame({LATCH_CLEAR_CMD, 32'h0}, 8, 1'b0);
    rd(8'h00);
    cpol <= 1'b0;
    status_write_cmd(8'hff);
    rd(8'h00);
    latch_set_cmd();
    status_write_cmd(8'hff);
    rd(8'h03);
    repeat (WC) @(posedge clk);
    rd(8'h8c);
    protect_pin_n <= 1'b0;
    latch_set_cmd();
    status_write_cmd(8'h00);
    rd(8'h8e);
    protect_pin_n <= 1'b1;
    status_write_cmd(8'h04);
    repeat (WC) @(posedge clk);
    rd(8'h04);
    latch_set_cmd();
    status_write_cmd(8'h0c, 17);
    rd(8'h06);
    i_host.frame({ARRAY_WRITE_CMD, 16'h1800, 16'ha500}, 32, 1'b0);
    rd(8'h06);
    a = 13'($urandom % 32'h1800);
    addr_q.push_back(a);
    i_host.frame({ARRAY_WRITE_CMD, 3'b000, a, 8'($urandom), 8'h00}, 32,
      1'b0);
    rd(8'h07);
    i_host.frame({ARRAY_READ_CMD, 32'($urandom)}, 40, 1'b0);
    repeat (WC) @(posedge clk);
    rd(8'h04);
    idx_q.push_back(5'h13);
    i_host.frame({ID_READ_CMD, 16'h0013, 16'h0000}, 32, 1'b0);
    i_host.frame({ID_READ_CMD, 16'h0413, 16'h0000}, 32, 1'b0);
    i_host.frame({ID_WRITE_CMD, 32'($urandom)}, 40, 1'b0);
    checks++;
    if (exp_q.size() != 0 || addr_q.size() != 0 || idx_q.size() != 0)
      fail("missing result");
    tally_and_finish();
  end
endmodule
`default_nettype wire
